// ===== src/adcsq_pkg.sv
// What this block does
// R1 - Single pass: start to end, then stop
// R2 - Continuous: wrap from end to start
// R3 - Pausing: halt per channel, wrap at end
// R4 - Each stored result raises interrupt request
// R5 - Interrupt request starts transfer service
// R6 - Trigger: software, timer, or external falling edge
// R7 - Result resolution eight or ten bits
// R8 - Eight channels, start and end select
// R9 - Conversion at least 6.12 us; an eight-bit result takes only 250 + 8 * 52 = 666 cycles, 5.33 us
// R10 - Sampling at least 2.0 us
// R11 - Successive approximation, MSB first
// R12 - Enable bit gates its own port pin
// R13 - Paused sequencer resumes on next trigger
// R14 - Busy shown; triggers ignored mid-conversion
package adcsq_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CHAN = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam logic [3:0] ADDR_INT_STAT = 4'h3;
    localparam logic [3:0] ADDR_INT_MASK = 4'h4;
    localparam logic [3:0] ADDR_RESULT = 4'h5;
    localparam logic [3:0] ADDR_PIN_EN = 4'h6;
    localparam logic [3:0] ADDR_SW_TRIG = 4'h7;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TSRC_LSB = 2;
    localparam int CTRL_RES8_BIT = 4;
    localparam int CTRL_XFER_BIT = 5;
    localparam int CHAN_END_LSB = 4;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] MODE_PAUSE = 2'h2;
    localparam logic [1:0] TSRC_SW = 2'h0;
    localparam logic [1:0] TSRC_TIMER = 2'h1;
    localparam logic [1:0] TSRC_EXT = 2'h2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CHAN_RESET = 8'h00;
    localparam logic [7:0] PIN_EN_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int CLK_MHZ = 125;
    localparam int CONV_NS = 6120;
    localparam int SAMPLE_NS = 2000;
    localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int RES_BITS = 10;
    localparam int STEP_CYC = (CONV_CYC - SAMPLE_CYC + RES_BITS - 1) / RES_BITS;
endpackage

// ===== src/adcsq_sar.sv
`timescale 1ns/100ps
module adcsq_sar #(
    parameter int BITS = 10,
    parameter int SAMPLE_CYC = 250,
    parameter int STEP_CYC = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic res8,
    output logic done,
    output logic [BITS-1:0] result,
    // Analog front end
    output logic hold,
    output logic [BITS-1:0] dac_code,
    input wire logic cmp_high
);
    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_STEP} adcsq_sar_st_t;
    typedef struct packed {
        adcsq_sar_st_t st;
        logic [15:0] cnt;
        logic [3:0] bit_idx;
        logic [BITS-1:0] code;
        logic [BITS-1:0] res;
        logic done;
    } adcsq_sar_t;
    adcsq_sar_t s_r, s_nxt;
    logic [3:0] last_idx;

    assign last_idx = res8 ? 4'(BITS - 8) : 4'h0;
    assign done = s_r.done;
    assign result = s_r.res;
    assign hold = (s_r.st == S_STEP);
    assign dac_code = s_r.code;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            S_IDLE: begin
                if (start) begin
                    s_nxt.st = S_SAMPLE;
                    s_nxt.cnt = 16'(SAMPLE_CYC - 1);
                end
            end
            S_SAMPLE: begin
                if (s_r.cnt == 16'h0000) begin // R10
                    s_nxt.st = S_STEP;
                    s_nxt.cnt = 16'(STEP_CYC - 1);
                    s_nxt.bit_idx = 4'(BITS - 1);
                    s_nxt.code = '0;
                    s_nxt.code[BITS-1] = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            S_STEP: begin
                if (s_r.cnt != 16'h0000) begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end else begin
                    s_nxt.cnt = 16'(STEP_CYC - 1);
                    if (!cmp_high) begin // R11
                        s_nxt.code[s_r.bit_idx] = 1'b0;
                    end
                    if (s_r.bit_idx <= last_idx) begin
                        s_nxt.st = S_IDLE;
                        s_nxt.done = 1'b1;
                        s_nxt.res = res8 ? (s_nxt.code >> (BITS - 8)) : s_nxt.code; // R7
                    end else begin
                        s_nxt.bit_idx = s_r.bit_idx - 4'h1;
                        s_nxt.code[s_r.bit_idx - 4'h1] = 1'b1; // R11
                    end
                end
            end
            default: s_nxt.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    a_sample_len: assert property (@(posedge clk) disable iff (rst) // R10
        $rose(s_r.st == S_SAMPLE) |-> (s_r.st == S_SAMPLE) [*8])
        else $error("Sampling phase ended too early");
    a_hold_steps: assert property (@(posedge clk) disable iff (rst) // R11
        $rose(hold) |-> dac_code[BITS-1])
        else $error("First step does not try the top bit");
endmodule

// ===== src/adcsq_top.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module adcsq_top #(
    parameter int CHANNELS = 8,
    parameter int BITS = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Triggers
    input wire logic timer_trig,
    input wire logic ext_trig_pin,
    // Analog front end
    output logic [2:0] mux_sel,
    output logic [CHANNELS-1:0] analog_pin_enable,
    output logic hold,
    output logic [BITS-1:0] dac_code,
    input wire logic cmp_high_pin,
    // Status and requests
    output logic busy,
    output logic irq,
    output logic xfer_req
);
    typedef enum logic [1:0] {Q_IDLE, Q_CONV, Q_PAUSE} adcsq_seq_st_t;
    typedef struct packed {
        adcsq_seq_st_t st;
        logic [7:0] ctrl;
        logic [7:0] chan;
        logic [7:0] pin_en;
        logic [7:0] mask;
        logic int_stat;
        logic [2:0] cur;
        logic [2:0] res_chan;
        logic [BITS-1:0] result;
        logic [15:0] rdata;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [1:0] cmp_sync;
        logic start;
        logic [15:0] age;
    } adcsq_top_t;
    adcsq_top_t s_r, s_nxt;

    logic [1:0] mode;
    logic [1:0] tsrc;
    logic [2:0] ch_start;
    logic [2:0] ch_end;
    logic sw_trig;
    logic ext_fall;
    logic trig;
    logic conv_done;
    logic [BITS-1:0] conv_result;

    assign mode = s_r.ctrl[adcsq_pkg::CTRL_MODE_LSB +: 2];
    assign tsrc = s_r.ctrl[adcsq_pkg::CTRL_TSRC_LSB +: 2];
    assign ch_start = s_r.chan[2:0]; // R8
    assign ch_end = s_r.chan[adcsq_pkg::CHAN_END_LSB +: 3]; // R8
    assign sw_trig = reg_wr && (reg_addr == adcsq_pkg::ADDR_SW_TRIG) && reg_wdata[0];
    assign ext_fall = s_r.ext_prev && !s_r.ext_sync[1];
    always_comb begin
        unique case (tsrc) // R6
            adcsq_pkg::TSRC_SW: trig = sw_trig;
            adcsq_pkg::TSRC_TIMER: trig = timer_trig;
            adcsq_pkg::TSRC_EXT: trig = ext_fall;
            default: trig = 1'b0;
        endcase
    end

    assign mux_sel = s_r.cur;
    assign analog_pin_enable = s_r.pin_en[CHANNELS-1:0]; // R12
    assign busy = (s_r.st != Q_IDLE); // R14
    assign irq = s_r.int_stat && s_r.mask[0]; // R4
    assign xfer_req = irq && s_r.ctrl[adcsq_pkg::CTRL_XFER_BIT]; // R5
    assign reg_rdata = s_r.rdata;

    adcsq_sar #(
        .BITS(BITS),
        .SAMPLE_CYC(adcsq_pkg::SAMPLE_CYC),
        .STEP_CYC(adcsq_pkg::STEP_CYC)
    ) u_sar (
        .clk(clk),
        .rst(rst),
        .start(s_r.start),
        .res8(s_r.ctrl[adcsq_pkg::CTRL_RES8_BIT]),
        .done(conv_done),
        .result(conv_result),
        .hold(hold),
        .dac_code(dac_code),
        .cmp_high(s_r.cmp_sync[1])
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.ext_sync = {s_r.ext_sync[0], ext_trig_pin};
        s_nxt.ext_prev = s_r.ext_sync[1];
        s_nxt.cmp_sync = {s_r.cmp_sync[0], cmp_high_pin};
        if (reg_wr) begin
            unique case (reg_addr)
                adcsq_pkg::ADDR_CTRL: s_nxt.ctrl = reg_wdata;
                adcsq_pkg::ADDR_CHAN: s_nxt.chan = reg_wdata;
                adcsq_pkg::ADDR_INT_MASK: s_nxt.mask = reg_wdata;
                adcsq_pkg::ADDR_PIN_EN: s_nxt.pin_en = reg_wdata; // R12
                adcsq_pkg::ADDR_INT_STAT: begin
                    if (reg_wdata[0]) begin
                        s_nxt.int_stat = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        unique case (s_r.st)
            Q_IDLE: begin
                if (trig) begin // R6
                    s_nxt.st = Q_CONV;
                    s_nxt.cur = ch_start;
                    s_nxt.start = 1'b1;
                end
            end
            Q_CONV: begin
                if (conv_done) begin // R14
                    s_nxt.result = conv_result;
                    s_nxt.res_chan = s_r.cur;
                    s_nxt.int_stat = 1'b1; // R4
                    if (s_r.cur == ch_end) begin
                        s_nxt.cur = ch_start;
                        if (mode == adcsq_pkg::MODE_CONT) begin // R2
                            s_nxt.start = 1'b1;
                        end else if (mode == adcsq_pkg::MODE_PAUSE) begin // R3
                            s_nxt.st = Q_PAUSE;
                        end else begin
                            s_nxt.st = Q_IDLE; // R1
                        end
                    end else begin
                        s_nxt.cur = s_r.cur + 3'h1; // R1
                        if (mode == adcsq_pkg::MODE_PAUSE) begin
                            s_nxt.st = Q_PAUSE; // R3
                        end else begin
                            s_nxt.start = 1'b1;
                        end
                    end
                end
            end
            Q_PAUSE: begin
                if (trig) begin // R13
                    s_nxt.st = Q_CONV;
                    s_nxt.start = 1'b1;
                end
            end
            default: s_nxt.st = Q_IDLE;
        endcase
        // Cycles since the last start
        if (s_r.start) begin
            s_nxt.age = 16'h0001;
        end else if (s_r.age != 16'hFFFF) begin
            s_nxt.age = s_r.age + 16'h0001;
        end
        s_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                adcsq_pkg::ADDR_CTRL: s_nxt.rdata = {8'h00, s_r.ctrl};
                adcsq_pkg::ADDR_CHAN: s_nxt.rdata = {8'h00, s_r.chan};
                adcsq_pkg::ADDR_STAT: s_nxt.rdata = {11'h000, s_r.res_chan, s_r.st == Q_PAUSE, busy};
                adcsq_pkg::ADDR_INT_STAT: s_nxt.rdata = {15'h0000, s_r.int_stat};
                adcsq_pkg::ADDR_INT_MASK: s_nxt.rdata = {8'h00, s_r.mask};
                adcsq_pkg::ADDR_RESULT: s_nxt.rdata = 16'(s_r.result);
                adcsq_pkg::ADDR_PIN_EN: s_nxt.rdata = {8'h00, s_r.pin_en};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= adcsq_pkg::CTRL_RESET;
            s_r.chan <= adcsq_pkg::CHAN_RESET;
            s_r.pin_en <= adcsq_pkg::PIN_EN_RESET;
            s_r.mask <= adcsq_pkg::MASK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    a_done_sets_int: assert property (@(posedge clk) disable iff (rst) // R4
        (s_r.st == Q_CONV && conv_done) |=> s_r.int_stat)
        else $error("Stored result did not set interrupt status");
    a_single_stops: assert property (@(posedge clk) disable iff (rst) // R1
        (s_r.st == Q_CONV && conv_done && s_r.cur == ch_end && mode == adcsq_pkg::MODE_SINGLE
         && !(reg_wr && reg_addr == adcsq_pkg::ADDR_CTRL)) |=> s_r.st == Q_IDLE)
        else $error("Single pass did not stop after end channel");
    a_cont_wraps: assert property (@(posedge clk) disable iff (rst) // R2
        (s_r.st == Q_CONV && conv_done && s_r.cur == ch_end && mode == adcsq_pkg::MODE_CONT
         && !reg_wr) |=> (s_r.cur == ch_start && s_r.start))
        else $error("Continuous mode did not restart at start channel");
    a_pause_halts: assert property (@(posedge clk) disable iff (rst) // R3
        (s_r.st == Q_CONV && conv_done && mode == adcsq_pkg::MODE_PAUSE && !reg_wr) |=> s_r.st == Q_PAUSE)
        else $error("Pausing mode did not halt");
    a_pause_resume: assert property (@(posedge clk) disable iff (rst) // R13
        (s_r.st == Q_PAUSE && !trig) |=> (s_r.st == Q_PAUSE && !s_r.start))
        else $error("Paused sequencer moved without trigger");
    a_busy_ignore: assert property (@(posedge clk) disable iff (rst) // R14
        (s_r.st == Q_CONV && !conv_done && trig) |=> !s_r.start)
        else $error("Trigger accepted during conversion");
    a_xfer_gate: assert property (@(posedge clk) disable iff (rst) // R5
        xfer_req |-> (s_r.int_stat && s_r.mask[0]))
        else $error("Transfer request without interrupt");
    a_conv_time: assert property (@(posedge clk) disable iff (rst) // R9
        s_r.start |=> !conv_done [*8])
        else $error("Conversion finished too fast");
    a_conv_length: assert property (@(posedge clk) disable iff (rst) // R9
        (conv_done && !s_r.ctrl[adcsq_pkg::CTRL_RES8_BIT])
        |-> (s_r.age >= 16'(adcsq_pkg::CONV_CYC)))
        else $error("Full conversion shorter than minimum");
    a_sw_start: assert property (@(posedge clk) disable iff (rst) // R6
        (s_r.st == Q_IDLE && tsrc == adcsq_pkg::TSRC_SW && sw_trig)
        |=> (s_r.st == Q_CONV && s_r.start))
        else $error("Software trigger did not start");
    a_timer_start: assert property (@(posedge clk) disable iff (rst) // R6
        (s_r.st == Q_IDLE && tsrc == adcsq_pkg::TSRC_TIMER && timer_trig)
        |=> (s_r.st == Q_CONV && s_r.start))
        else $error("Timer trigger did not start");
    a_ext_start: assert property (@(posedge clk) disable iff (rst) // R6
        (s_r.st == Q_IDLE && tsrc == adcsq_pkg::TSRC_EXT && ext_fall)
        |=> (s_r.st == Q_CONV && s_r.start))
        else $error("External falling edge did not start");
    a_idle_waits: assert property (@(posedge clk) disable iff (rst) // R6
        (s_r.st == Q_IDLE && !trig)
        |=> (s_r.st == Q_IDLE && !s_r.start))
        else $error("Started without selected trigger");
    a_first_chan: assert property (@(posedge clk) disable iff (rst) // R1
        (s_r.st == Q_IDLE && trig)
        |=> (mux_sel == $past(ch_start)))
        else $error("Sequence did not begin at start channel");
    a_next_chan: assert property (@(posedge clk) disable iff (rst) // R1
        (s_r.st == Q_CONV && conv_done && s_r.cur != ch_end)
        |=> (mux_sel == 3'($past(s_r.cur) + 3'h1)))
        else $error("Channel did not advance by one");
    a_single_next: assert property (@(posedge clk) disable iff (rst) // R1
        (s_r.st == Q_CONV && conv_done && s_r.cur != ch_end && mode == adcsq_pkg::MODE_SINGLE)
        |=> s_r.start)
        else $error("Single pass stopped before end channel");
    a_cont_next: assert property (@(posedge clk) disable iff (rst) // R2
        (s_r.st == Q_CONV && conv_done && s_r.cur != ch_end && mode == adcsq_pkg::MODE_CONT)
        |=> s_r.start)
        else $error("Continuous mode did not go on");
    a_pause_wrap: assert property (@(posedge clk) disable iff (rst) // R3
        (s_r.st == Q_CONV && conv_done && s_r.cur == ch_end && mode == adcsq_pkg::MODE_PAUSE && !reg_wr)
        |=> (s_r.st == Q_PAUSE && s_r.cur == ch_start))
        else $error("Pausing mode did not wrap to start");
    a_result_kept: assert property (@(posedge clk) disable iff (rst) // R4
        (s_r.st == Q_CONV && conv_done)
        |=> (s_r.result == $past(conv_result) && s_r.res_chan == $past(s_r.cur)))
        else $error("Result not stored with its channel");
    a_int_sticky: assert property (@(posedge clk) disable iff (rst) // R4
        (s_r.int_stat && !(reg_wr && reg_addr == adcsq_pkg::ADDR_INT_STAT))
        |=> s_r.int_stat)
        else $error("Interrupt status lost without clear");
    a_int_clear: assert property (@(posedge clk) disable iff (rst) // R4
        (reg_wr && reg_addr == adcsq_pkg::ADDR_INT_STAT && reg_wdata[0] && !(s_r.st == Q_CONV && conv_done))
        |=> !s_r.int_stat)
        else $error("Interrupt status not cleared");
    a_xfer_follows: assert property (@(posedge clk) disable iff (rst) // R5
        (irq && s_r.ctrl[adcsq_pkg::CTRL_XFER_BIT])
        |-> xfer_req)
        else $error("Transfer request missing");
    a_xfer_off: assert property (@(posedge clk) disable iff (rst) // R5
        !s_r.ctrl[adcsq_pkg::CTRL_XFER_BIT]
        |-> !xfer_req)
        else $error("Transfer request while disabled");
    a_res8_align: assert property (@(posedge clk) disable iff (rst) // R7
        (conv_done && s_r.ctrl[adcsq_pkg::CTRL_RES8_BIT])
        |-> (conv_result[BITS-1:8] == '0))
        else $error("Eight-bit result not right aligned");
    a_pin_write: assert property (@(posedge clk) disable iff (rst) // R12
        (reg_wr && reg_addr == adcsq_pkg::ADDR_PIN_EN)
        |=> (analog_pin_enable == $past(reg_wdata[CHANNELS-1:0])))
        else $error("Pin enable write not applied");
    a_pin_holds: assert property (@(posedge clk) disable iff (rst) // R12
        !(reg_wr && reg_addr == adcsq_pkg::ADDR_PIN_EN)
        |=> $stable(analog_pin_enable))
        else $error("Pin enable changed without write");
    a_resume_same: assert property (@(posedge clk) disable iff (rst) // R13
        (s_r.st == Q_PAUSE && trig)
        |=> (s_r.st == Q_CONV && s_r.start && mux_sel == $past(mux_sel)))
        else $error("Paused sequencer did not resume");
    a_hold_busy: assert property (@(posedge clk) disable iff (rst) // R14
        hold
        |-> busy)
        else $error("Converter active while not busy");
    a_conv_stays: assert property (@(posedge clk) disable iff (rst) // R14
        (s_r.st == Q_CONV && !conv_done)
        |=> (s_r.st == Q_CONV))
        else $error("Conversion left before its result");
    c_single: cover property (@(posedge clk) s_r.st == Q_CONV ##1 s_r.st == Q_IDLE);
    c_pause: cover property (@(posedge clk) s_r.st == Q_PAUSE ##1 s_r.st == Q_CONV);
    c_ext: cover property (@(posedge clk) ext_fall && tsrc == adcsq_pkg::TSRC_EXT);
    c_irq: cover property (@(posedge clk) $rose(irq));
    c_wrap: cover property (@(posedge clk) s_r.st == Q_CONV && conv_done && s_r.cur == ch_end);
endmodule

// ===== tb/adcsq_analog_model.sv
`timescale 1ns/100ps
module adcsq_analog_model (
    // Clock
    input wire logic clk,
    // Converter side
    input wire logic [2:0] mux_sel,
    input wire logic hold,
    input wire logic [9:0] dac_code,
    output logic cmp_high_pin,
    // Trigger sources
    output logic timer_trig,
    output logic ext_trig_pin
);
    logic scramble_r = 1'b0;
    initial begin
        timer_trig = 1'b0;
        ext_trig_pin = 1'b1;
    end
    // Comparator valid only on a held sample, otherwise noise
    assign cmp_high_pin = hold ? ({mux_sel, 7'h2B} >= dac_code) : scramble_r;
    always @(posedge clk) begin
        scramble_r <= ~scramble_r;
    end
    // One-cycle timer pulse
    task automatic pulse_timer();
        @(posedge clk);
        timer_trig <= 1'b1;
        @(posedge clk);
        timer_trig <= 1'b0;
    endtask
    // Falling edge on the external pin, held low a few cycles
    task automatic fall_ext();
        @(posedge clk);
        ext_trig_pin <= 1'b0;
        repeat (4) @(posedge clk);
        ext_trig_pin <= 1'b1;
    endtask
endmodule

// ===== tb/test_adcsq_top.sv
`timescale 1ns/100ps
module test_adcsq_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic timer_trig, ext_trig_pin, cmp_high_pin, hold, busy, irq, xfer_req;
    logic [2:0] mux_sel;
    logic [7:0] analog_pin_enable;
    logic [9:0] dac_code;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [15:0] d;

    always #4 clk = ~clk;

    adcsq_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin),
        .mux_sel(mux_sel), .analog_pin_enable(analog_pin_enable), .hold(hold), .dac_code(dac_code),
        .cmp_high_pin(cmp_high_pin), .busy(busy), .irq(irq), .xfer_req(xfer_req));
    adcsq_analog_model model_u (.clk(clk), .mux_sel(mux_sel), .hold(hold), .dac_code(dac_code),
        .cmp_high_pin(cmp_high_pin), .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin));

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Wait for a stored result, check channel, value and transfer request, then clear
    task automatic wait_res(input logic [2:0] ch, input logic r8, input logic xf);
        int n;
        n = 0;
        #1;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        chk(irq, 1'b1);
        chk(xfer_req, xf);
        rd(adcsq_pkg::ADDR_RESULT);
        chk(d, r8 ? {8'h00, ch, 5'h0A} : {6'h00, ch, 7'h2B});
        rd(adcsq_pkg::ADDR_STAT);
        chk(d[4:2], ch);
        wr(adcsq_pkg::ADDR_INT_STAT, 8'h01);
    endtask

    task automatic test_regs();
        rd(adcsq_pkg::ADDR_CTRL);
        chk(d, 16'h0000);
        rd(adcsq_pkg::ADDR_PIN_EN);
        chk(d, 16'h0000);
        rd(4'hF);
        chk(d, 16'h0000);
        wr(adcsq_pkg::ADDR_PIN_EN, 8'hA5);
        rd(adcsq_pkg::ADDR_PIN_EN);
        chk(d, 16'h00A5);
        chk(analog_pin_enable, 8'hA5);
        $display("test_regs done");
    endtask

    task automatic test_single();
        int t0;
        wr(adcsq_pkg::ADDR_INT_MASK, 8'h01);
        wr(adcsq_pkg::ADDR_CHAN, 8'h76);
        wr(adcsq_pkg::ADDR_CTRL, 8'h00);
        wr(adcsq_pkg::ADDR_SW_TRIG, 8'h01);
        t0 = cyc;
        repeat (3) @(posedge clk);
        #1 chk(busy, 1'b1);
        wr(adcsq_pkg::ADDR_SW_TRIG, 8'h01);
        repeat (230) @(posedge clk);
        #1 chk(hold, 1'b0);
        wait_res(3'h6, 1'b0, 1'b0);
        chk(16'((cyc - t0) >= 765), 16'h0001);
        wait_res(3'h7, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        #1 chk(busy, 1'b0);
        repeat (900) @(posedge clk);
        #1 chk(irq, 1'b0);
        $display("test_single done");
    endtask

    task automatic test_cont();
        wr(adcsq_pkg::ADDR_CHAN, 8'h07);
        wr(adcsq_pkg::ADDR_CTRL, 8'h35);
        model_u.pulse_timer();
        wait_res(3'h7, 1'b1, 1'b1);
        wait_res(3'h0, 1'b1, 1'b1);
        wait_res(3'h7, 1'b1, 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk(busy, 1'b0);
        chk(analog_pin_enable, 8'h00);
        $display("test_cont done");
    endtask

    task automatic test_pause();
        wr(adcsq_pkg::ADDR_CHAN, 8'h32);
        wr(adcsq_pkg::ADDR_CTRL, 8'h0A);
        model_u.fall_ext();
        repeat (900) @(posedge clk);
        #1 chk(irq, 1'b0);
        rd(adcsq_pkg::ADDR_INT_STAT);
        chk(d, 16'h0001);
        wr(adcsq_pkg::ADDR_INT_MASK, 8'h01);
        wait_res(3'h2, 1'b0, 1'b0);
        #1 chk(busy, 1'b1);
        wr(adcsq_pkg::ADDR_SW_TRIG, 8'h01);
        model_u.pulse_timer();
        repeat (900) @(posedge clk);
        #1 chk(irq, 1'b0);
        model_u.fall_ext();
        wait_res(3'h3, 1'b0, 1'b0);
        model_u.fall_ext();
        wait_res(3'h2, 1'b0, 1'b0);
        $display("test_pause done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_single();
        test_cont();
        test_pause();
        complete_run();
    end
endmodule
